// ==== src/lkp_entry_write.sv ====
// Lookup table entry staging registers, make-entry engine and table
// Behaviour
// R1 - Upper 32-bit staging word at register 1802h feeds the committed entry.
// R2 - Bit 24 marks entry valid; written zero invalidates entry with that MAC.
// R3 - Software sets bit 23 on non-static entries so they age normally.
// R4 - Static entry with bit 23 forwards matching DA ignoring port state.
// R5 - Bit 22 entries are exempt from aging and from learning changes.
// R6 - Non-static entries vanish after 5 to 10 minutes without SA hits.
// R7 - Software clears static bit when invalidating; sets it for manual adds.
// R8 - Bit 21 set discards packets whose DA matches the entry.
// R9 - Bits 20:19 priority apply only to static entries with enable bit 5.
// R10 - Port field bit 18 clear names one port, set names several.
// R11 - Port codes: host, one, two, reserved, pairs, then all three.
// R12 - Bits 15:0 hold last 16 MAC bits; bit 15 is last on wire.
// R13 - Make-entry command commits both staging words, adds/changes/deletes.
// R14 - Lower staging word holds first 32 MAC bits; bit 0 multicast.
// R15 - Software clears the make bit once status shows completion.
// R16 - Staging word holds until overwritten; bits 31:25 read zero.
//
// Added by the designer: the plain strobed port.
`timescale 1ns/1ps
module lkp_entry_write #(
   parameter int DEPTH = 64,
   parameter logic [39:0] AGE_TICK_CYCLES = lkp_pkg::AGE_TICK_CYCLES
) (
   input wire logic clock_i,
   input wire logic rst_i,
   // Register port
   input wire logic [15:0] reg_addr_i,
   input wire logic [31:0] reg_wdata_i,
   input wire logic reg_wr_i,
   input wire logic reg_rd_i,
   output logic [31:0] reg_rdata_o,
   // Per-port forwarding state, bit n for port n
   input wire logic [2:0] port_forwarding_i,
   // Packet lookup request
   input wire logic lookup_req_i,
   input wire logic [47:0] lookup_da_i,
   input wire logic [47:0] lookup_sa_i,
   input wire logic [1:0] lookup_src_port_i,
   // Lookup answer, one cycle after the request
   output logic lookup_done_o,
   output logic lookup_hit_o,
   output logic lookup_drop_o,
   output logic [2:0] lookup_egress_o,
   output logic [1:0] lookup_prio_o,
   output logic lookup_prio_valid_o
);
   localparam int IDX_W = (DEPTH > 1) ? $clog2(DEPTH) : 1;

   typedef struct packed {
      // Table, staging words and command state
      lkp_pkg::lkp_entry_type [DEPTH-1:0] entries;
      logic cmd_make;
      logic [31:0] wr_low;
      logic [24:0] wr_high;
      logic da_prio_en;
      logic [31:0] rd_data;
      lkp_pkg::lkp_make_state_type mstate;
      logic [IDX_W-1:0] mk_idx;
      logic mk_ok;
      // Registered lookup answer, cleared in every cycle without a request
      logic done;
      logic hit;
      logic drop;
      logic [2:0] egress;
      logic [1:0] prio;
      logic prio_valid;
   } lkp_state_type;

   lkp_state_type s_r;
   lkp_state_type s_nxt;

   logic age_tick;
   logic [47:0] staged_mac;
   logic [DEPTH-1:0] da_match;
   logic [DEPTH-1:0] sa_match;
   logic [DEPTH-1:0] mk_match;
   logic [DEPTH-1:0] slot_free;
   logic [IDX_W-1:0] da_idx;
   logic [IDX_W-1:0] sa_idx;
   logic [IDX_W-1:0] mk_idx;
   logic [IDX_W-1:0] free_idx;
   lkp_pkg::lkp_entry_type da_entry;
   logic [2:0] da_map;
   logic da_reserved;

   // One sweep per period, so an idle entry lives one to two periods
   lkp_age_timer #(
      .TICK_CYCLES(AGE_TICK_CYCLES)
   ) u_age_timer (
      .clock_i(clock_i),
      .rst_i(rst_i),
      .tick_o(age_tick)
   );

   // First 32 MAC bits from the low word, last 16 from the high word
   assign staged_mac = {s_r.wr_high[lkp_pkg::HIGH_MAC_HI:0],
                        s_r.wr_low};  // [R12] [R14]

   genvar g;
   generate
      for (g = 0; g < DEPTH; g++) begin : g_match
         assign da_match[g] = s_r.entries[g].valid &&
                              (s_r.entries[g].mac == lookup_da_i);
         assign sa_match[g] = s_r.entries[g].valid &&
                              (s_r.entries[g].mac == lookup_sa_i);
         assign mk_match[g] = s_r.entries[g].valid &&
                              (s_r.entries[g].mac == staged_mac);
         assign slot_free[g] = !s_r.entries[g].valid;
      end
   endgenerate

   // Lowest-index encoders; a MAC is never held twice so order is moot
   always_comb begin
      da_idx = '0;
      sa_idx = '0;
      mk_idx = '0;
      free_idx = '0;
      for (int i = DEPTH - 1; i >= 0; i--) begin
         if (da_match[i]) begin
            da_idx = IDX_W'(i);
         end
         if (sa_match[i]) begin
            sa_idx = IDX_W'(i);
         end
         if (mk_match[i]) begin
            mk_idx = IDX_W'(i);
         end
         if (slot_free[i]) begin
            free_idx = IDX_W'(i);
         end
      end
   end

   assign da_entry = s_r.entries[da_idx];

   lkp_port_decode u_port_decode (
      .code_i(da_entry.port),
      .map_o(da_map),
      .reserved_o(da_reserved)
   );

   always_comb begin
      logic start;
      logic override;
      logic ingress_ok;
      lkp_pkg::lkp_entry_type e;
      start = 1'b0;
      override = 1'b0;
      ingress_ok = 1'b0;
      e = '0;
      s_nxt = s_r;
      s_nxt.done = 1'b0;
      s_nxt.hit = 1'b0;
      s_nxt.drop = 1'b0;
      s_nxt.egress = 3'h0;
      s_nxt.prio = 2'h0;
      s_nxt.prio_valid = 1'b0;
      s_nxt.rd_data = 32'h0000_0000;

      // Register reads; unmapped numbers read zero
      if (reg_rd_i) begin
         case (reg_addr_i)
            lkp_pkg::REG_CMD: begin
               // Only the make bit exists; the other command bits read zero
               s_nxt.rd_data[lkp_pkg::CMD_MAKE_BIT] = s_r.cmd_make;
            end
            lkp_pkg::REG_WR_LOW: begin
               s_nxt.rd_data = s_r.wr_low;
            end
            lkp_pkg::REG_WR_HIGH: begin
               s_nxt.rd_data = {7'h00, s_r.wr_high};  // [R16]
            end
            lkp_pkg::REG_STATUS: begin
               // Pending covers search and commit, so one poll may see it
               s_nxt.rd_data[lkp_pkg::STATUS_PENDING_BIT] =
                  (s_r.mstate != lkp_pkg::MK_IDLE);
            end
            lkp_pkg::REG_INGRESS: begin
               s_nxt.rd_data[lkp_pkg::INGRESS_DA_PRIO_BIT] = s_r.da_prio_en;
            end
            default: begin
               s_nxt.rd_data = 32'h0000_0000;
            end
         endcase
      end

      // Register writes
      if (reg_wr_i) begin
         case (reg_addr_i)
            lkp_pkg::REG_CMD: begin
               // Only a 0-to-1 change starts a command, so a bit left set
               // until software clears it cannot re-trigger a commit
               start = reg_wdata_i[lkp_pkg::CMD_MAKE_BIT] &&
                       !s_r.cmd_make &&
                       (s_r.mstate == lkp_pkg::MK_IDLE);  // [R13]
               s_nxt.cmd_make = reg_wdata_i[lkp_pkg::CMD_MAKE_BIT];  // [R15]
            end
            lkp_pkg::REG_WR_LOW: begin
               s_nxt.wr_low = reg_wdata_i;  // [R14]
            end
            lkp_pkg::REG_WR_HIGH: begin
               // Bits 31:25 are dropped here and so read back as zero
               s_nxt.wr_high = reg_wdata_i[lkp_pkg::HIGH_WIDTH-1:0];  // [R1]
            end
            lkp_pkg::REG_INGRESS: begin
               s_nxt.da_prio_en = reg_wdata_i[lkp_pkg::INGRESS_DA_PRIO_BIT];
            end
            default: begin
            end
         endcase
      end

      // Aging sweep: the first quiet sweep clears the age bit, the second removes
      if (age_tick) begin
         for (int i = 0; i < DEPTH; i++) begin
            if (s_r.entries[i].valid && !s_r.entries[i].stat) begin  // [R5]
               if (s_r.entries[i].age) begin
                  s_nxt.entries[i].age = 1'b0;  // [R3]
               end else begin
                  s_nxt.entries[i].valid = 1'b0;  // [R6]
               end
            end
         end
      end

      // Make-entry engine; staging words are read, never altered
      case (s_r.mstate)
         lkp_pkg::MK_IDLE: begin
            if (start) begin
               s_nxt.mstate = lkp_pkg::MK_SEARCH;
            end
         end
         lkp_pkg::MK_SEARCH: begin
            // A MAC already held is rewritten in place, never stored twice
            if (|mk_match) begin
               s_nxt.mk_idx = mk_idx;
               s_nxt.mk_ok = 1'b1;
            end else begin
               s_nxt.mk_idx = free_idx;
               s_nxt.mk_ok = (|slot_free) &&
                             s_r.wr_high[lkp_pkg::HIGH_VALID_BIT];
            end
            s_nxt.mstate = lkp_pkg::MK_COMMIT;
         end
         lkp_pkg::MK_COMMIT: begin
            if (s_r.mk_ok) begin  // [R13]
               e.valid = s_r.wr_high[lkp_pkg::HIGH_VALID_BIT];  // [R2]
               e.age = s_r.wr_high[lkp_pkg::HIGH_AGE_BIT];
               e.stat = s_r.wr_high[lkp_pkg::HIGH_STATIC_BIT];
               e.filter = s_r.wr_high[lkp_pkg::HIGH_FILTER_BIT];
               e.prio = s_r.wr_high[lkp_pkg::HIGH_PRIO_HI:
                                    lkp_pkg::HIGH_PRIO_LO];
               e.port = s_r.wr_high[lkp_pkg::HIGH_PORT_HI:
                                    lkp_pkg::HIGH_PORT_LO];
               e.mac = staged_mac;
               // An invalid write clears the whole slot
               s_nxt.entries[s_r.mk_idx] = e.valid ? e : '0;  // [R2] [R7]
            end
            s_nxt.mk_ok = 1'b0;
            s_nxt.mstate = lkp_pkg::MK_IDLE;
         end
         default: begin
            s_nxt.mk_ok = 1'b0;
            s_nxt.mstate = lkp_pkg::MK_IDLE;
         end
      endcase

      // Lookup answer
      if (lookup_req_i) begin
         // Port code 3 names no port, so it never counts as forwarding
         case (lookup_src_port_i)
            2'h0: ingress_ok = port_forwarding_i[0];
            2'h1: ingress_ok = port_forwarding_i[1];
            2'h2: ingress_ok = port_forwarding_i[2];
            default: ingress_ok = 1'b0;
         endcase
         override = da_entry.stat && da_entry.age;  // [R4]
         s_nxt.done = 1'b1;
         s_nxt.hit = |da_match;
         if (|da_match) begin
            // Filter and reserved code win over override: no leak
            if (da_entry.filter || da_reserved) begin
               s_nxt.drop = 1'b1;  // [R8]
            end else if (override) begin
               s_nxt.egress = da_map;  // [R4]
            end else if (ingress_ok) begin
               // Egress ports outside forwarding state are masked off
               s_nxt.egress = da_map & port_forwarding_i;
            end else begin
               s_nxt.drop = 1'b1;
            end
            s_nxt.prio = da_entry.prio;
            s_nxt.prio_valid = da_entry.stat && s_r.da_prio_en;  // [R9]
         end
      end

      // Learning is held off while a command owns the free-slot choice
      if (lookup_req_i && (s_r.mstate == lkp_pkg::MK_IDLE) &&
          (lookup_src_port_i < 2'h3)) begin
         // Static entries keep their port; learning may not move them
         if (|sa_match) begin
            if (!s_r.entries[sa_idx].stat) begin  // [R5]
               s_nxt.entries[sa_idx].valid = 1'b1;
               s_nxt.entries[sa_idx].age = 1'b1;  // [R6]
               s_nxt.entries[sa_idx].port = {1'b0, lookup_src_port_i};
            end
         end else if ((|slot_free) &&
                      !lookup_sa_i[lkp_pkg::MAC_MCAST_BIT]) begin
            e = '0;
            e.valid = 1'b1;
            e.age = 1'b1;
            e.port = {1'b0, lookup_src_port_i};
            e.mac = lookup_sa_i;
            s_nxt.entries[free_idx] = e;
         end
      end
   end

   // Reset empties the table; static entries must be added again
   always_ff @(posedge clock_i) begin
      if (rst_i) begin
         s_r <= '0;
         s_r.cmd_make <= lkp_pkg::CMD_MAKE_RESET;
         s_r.wr_low <= lkp_pkg::WR_LOW_RESET;
         s_r.wr_high <= lkp_pkg::WR_HIGH_RESET;
         s_r.da_prio_en <= lkp_pkg::DA_PRIO_EN_RESET;
         s_r.mstate <= lkp_pkg::MK_IDLE;
      end else begin
         s_r <= s_nxt;
      end
   end

   assign reg_rdata_o = s_r.rd_data;
   assign lookup_done_o = s_r.done;
   assign lookup_hit_o = s_r.hit;
   assign lookup_drop_o = s_r.drop;
   assign lookup_egress_o = s_r.egress;
   assign lookup_prio_o = s_r.prio;
   assign lookup_prio_valid_o = s_r.prio_valid;
endmodule // lkp_entry_write

// ==== src/lkp_pkg.sv ====
// Constants and types shared by the lookup entry write block
package lkp_pkg;

   // Register numbers, as seen on the plain register port
   localparam logic [15:0] REG_CMD = 16'h1800;
   localparam logic [15:0] REG_WR_LOW = 16'h1801;
   localparam logic [15:0] REG_WR_HIGH = 16'h1802;
   localparam logic [15:0] REG_STATUS = 16'h1807;
   localparam logic [15:0] REG_INGRESS = 16'h1840;

   // Field positions
   localparam int CMD_MAKE_BIT = 2;
   localparam int HIGH_VALID_BIT = 24;
   localparam int HIGH_AGE_BIT = 23;
   localparam int HIGH_STATIC_BIT = 22;
   localparam int HIGH_FILTER_BIT = 21;
   localparam int HIGH_PRIO_HI = 20;
   localparam int HIGH_PRIO_LO = 19;
   localparam int HIGH_PORT_HI = 18;
   localparam int HIGH_PORT_LO = 16;
   localparam int HIGH_MAC_HI = 15;
   localparam int HIGH_WIDTH = 25;
   localparam int STATUS_PENDING_BIT = 0;
   localparam int INGRESS_DA_PRIO_BIT = 5;
   localparam int MAC_MCAST_BIT = 0;

   // Reset values
   localparam logic [31:0] WR_LOW_RESET = 32'h0000_0000;
   localparam logic [24:0] WR_HIGH_RESET = 25'h000_0000;
   localparam logic CMD_MAKE_RESET = 1'b0;
   localparam logic DA_PRIO_EN_RESET = 1'b0;

   // Port field codes
   localparam int NUM_PORTS = 3;
   localparam logic [2:0] PORT_HOST = 3'h0;
   localparam logic [2:0] PORT_ONE = 3'h1;
   localparam logic [2:0] PORT_TWO = 3'h2;
   localparam logic [2:0] PORT_RSVD = 3'h3;
   localparam logic [2:0] PORT_HOST_ONE = 3'h4;
   localparam logic [2:0] PORT_HOST_TWO = 3'h5;
   localparam logic [2:0] PORT_ONE_TWO = 3'h6;
   localparam logic [2:0] PORT_ALL = 3'h7;

   // Aging: two sweeps of this period remove an idle entry
   localparam longint AGE_PERIOD_MIN = 5;
   localparam longint CLOCK_HZ = 50_000_000;
   localparam logic [39:0] AGE_TICK_CYCLES =
      40'(AGE_PERIOD_MIN * 64'd60 * CLOCK_HZ);

   typedef enum logic [1:0] {
      MK_IDLE = 2'h0,
      MK_SEARCH = 2'h1,
      MK_COMMIT = 2'h3
   } lkp_make_state_type;

   typedef struct packed {
      logic valid;
      logic age;
      logic stat;
      logic filter;
      logic [1:0] prio;
      logic [2:0] port;
      logic [47:0] mac;
   } lkp_entry_type;

endpackage

// ==== src/lkp_port_decode.sv ====
// Decoder from the three-bit entry port field to a port bit map
`timescale 1ns/1ps
module lkp_port_decode (
   input wire logic [2:0] code_i,
   output logic [2:0] map_o,
   output logic reserved_o
);
   always_comb begin
      reserved_o = 1'b0;
      case (code_i)  // [R10] [R11]
         lkp_pkg::PORT_HOST: map_o = 3'h1;
         lkp_pkg::PORT_ONE: map_o = 3'h2;
         lkp_pkg::PORT_TWO: map_o = 3'h4;
         lkp_pkg::PORT_HOST_ONE: map_o = 3'h3;
         lkp_pkg::PORT_HOST_TWO: map_o = 3'h5;
         lkp_pkg::PORT_ONE_TWO: map_o = 3'h6;
         lkp_pkg::PORT_ALL: map_o = 3'h7;
         default: begin
            // Reserved code selects nothing
            map_o = 3'h0;
            reserved_o = 1'b1;
         end
      endcase
   end
endmodule // lkp_port_decode

// ==== src/lkp_age_timer.sv ====
// Free-running timer that pulses once per aging period
`timescale 1ns/1ps
module lkp_age_timer #(
   parameter logic [39:0] TICK_CYCLES = lkp_pkg::AGE_TICK_CYCLES
) (
   input wire logic clock_i,
   input wire logic rst_i,
   output logic tick_o
);
   typedef struct packed {
      logic [39:0] count;
      logic tick;
   } lkp_timer_state_type;

   lkp_timer_state_type s_r;
   lkp_timer_state_type s_nxt;

   always_comb begin
      s_nxt = s_r;
      s_nxt.tick = 1'b0;
      if (s_r.count >= TICK_CYCLES - 40'h1) begin  // [R6]
         s_nxt.count = 40'h0;
         s_nxt.tick = 1'b1;
      end else begin
         s_nxt.count = s_r.count + 40'h1;
      end
   end

   always_ff @(posedge clock_i) begin
      if (rst_i) begin
         s_r <= '0;
      end else begin
         s_r <= s_nxt;
      end
   end

   assign tick_o = s_r.tick;
endmodule // lkp_age_timer

// ==== tb/lkp_entry_write_assertions.sv ====
// Port-level assertions for the lookup entry write block
`timescale 1ns/1ps
module lkp_ew_checker (
   input wire logic clock_i,
   input wire logic rst_i,
   input wire logic [15:0] reg_addr_i,
   input wire logic [31:0] reg_wdata_i,
   input wire logic reg_wr_i,
   input wire logic reg_rd_i,
   input wire logic [31:0] reg_rdata_o,
   input wire logic lookup_req_i,
   input wire logic lookup_done_o,
   input wire logic lookup_hit_o,
   input wire logic lookup_drop_o,
   input wire logic [2:0] lookup_egress_o,
   input wire logic lookup_prio_valid_o
);
   logic [24:0] high_r;
   logic make_r;
   logic da_en_r;
   logic [1:0] pend_r;
   logic wr_cmd;
   logic mapped;
   assign wr_cmd = reg_wr_i && reg_addr_i == lkp_pkg::REG_CMD;
   assign mapped = reg_addr_i inside {lkp_pkg::REG_CMD, lkp_pkg::REG_WR_LOW,
      lkp_pkg::REG_WR_HIGH, lkp_pkg::REG_STATUS, lkp_pkg::REG_INGRESS};
   // Shadows of software writes, so read-back is judged from the port only
   always_ff @(posedge clock_i) begin
      if (rst_i) begin
         high_r <= 25'h0000000;
         make_r <= 1'b0;
         da_en_r <= 1'b0;
         pend_r <= 2'h0;
      end else begin
         if (reg_wr_i && reg_addr_i == lkp_pkg::REG_WR_HIGH)
            high_r <= reg_wdata_i[24:0];
         if (wr_cmd && reg_wdata_i[2] && !make_r && pend_r == 2'h0)
            pend_r <= 2'h2;
         else if (pend_r != 2'h0)
            pend_r <= pend_r - 2'h1;
         if (wr_cmd)
            make_r <= reg_wdata_i[2];
         if (reg_wr_i && reg_addr_i == lkp_pkg::REG_INGRESS)
            da_en_r <= reg_wdata_i[5];
      end
   end
   default clocking @(posedge clock_i); endclocking
   default disable iff (rst_i);
   sequence s_read(logic [15:0] a);
      reg_rd_i && reg_addr_i == a;
   endsequence
   sequence s_make_start;
      wr_cmd && reg_wdata_i[2] && !make_r && pend_r == 2'h0;
   endsequence
   property p_rdata_idle;
      !reg_rd_i |=> reg_rdata_o == 32'h0000_0000;
   endproperty
   a_rdata_idle: assert property (p_rdata_idle)
      else $error("read data not zero outside a read answer");
   property p_unmapped;
      reg_rd_i && !mapped |=> reg_rdata_o == 32'h0000_0000;
   endproperty
   a_unmapped: assert property (p_unmapped)
      else $error("unmapped read returned data");
   property p_high_readback;
      s_read(lkp_pkg::REG_WR_HIGH) |=> reg_rdata_o == {7'h00, $past(high_r)};
   endproperty
   a_high_readback: assert property (p_high_readback)
      else $error("upper staging word read-back wrong");
   property p_cmd_readback;
      s_read(lkp_pkg::REG_CMD) |=> reg_rdata_o == {29'h0, $past(make_r), 2'h0};
   endproperty
   a_cmd_readback: assert property (p_cmd_readback)
      else $error("command register read-back wrong");
   property p_status;
      s_read(lkp_pkg::REG_STATUS) |=>
         reg_rdata_o == {31'h0, $past(pend_r) != 2'h0};
   endproperty
   a_status: assert property (p_status)
      else $error("pending flag read wrong");
   property p_make_pending;
      s_make_start ##1 s_read(lkp_pkg::REG_STATUS) |=>
         reg_rdata_o == 32'h0000_0001;
   endproperty
   a_make_pending: assert property (p_make_pending)
      else $error("pending not shown right after make entry");
   property p_done_latency;
      lookup_req_i |=> lookup_done_o;
   endproperty
   a_done_latency: assert property (p_done_latency)
      else $error("lookup answer missing one cycle after request");
   property p_quiet;
      !lookup_req_i |=> !lookup_done_o && !lookup_hit_o && !lookup_drop_o &&
         lookup_egress_o == 3'h0 && !lookup_prio_valid_o;
   endproperty
   a_quiet: assert property (p_quiet)
      else $error("lookup answer without a request");
   property p_prio_valid;
      lookup_prio_valid_o |-> lookup_hit_o && $past(da_en_r);
   endproperty
   a_prio_valid: assert property (p_prio_valid)
      else $error("priority used without hit or enable");
endmodule // lkp_ew_checker

bind lkp_entry_write lkp_ew_checker chk_u (
   .clock_i(clock_i), .rst_i(rst_i), .reg_addr_i(reg_addr_i),
   .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i),
   .reg_rdata_o(reg_rdata_o), .lookup_req_i(lookup_req_i),
   .lookup_done_o(lookup_done_o), .lookup_hit_o(lookup_hit_o),
   .lookup_drop_o(lookup_drop_o), .lookup_egress_o(lookup_egress_o),
   .lookup_prio_valid_o(lookup_prio_valid_o)
);

// ==== tb/lkp_entry_write_tb_top.sv ====
// Self-checking bench for the lookup entry write block
`timescale 1ns/1ps
module lkp_entry_write_tb_top;
   localparam logic [31:0] LOW = 32'h4433_2210;
   logic clock_i = 1'b0;
   logic rst_i = 1'b1;
   logic [15:0] reg_addr_i = 16'h0000;
   logic [31:0] reg_wdata_i = 32'h0000_0000;
   logic reg_wr_i = 1'b0;
   logic reg_rd_i = 1'b0;
   logic [31:0] reg_rdata_o;
   logic [2:0] port_forwarding_i = 3'h7;
   logic lookup_req_i = 1'b0;
   logic [47:0] lookup_da_i = 48'h0;
   // Multicast source address keeps learning out of the table
   logic [47:0] lookup_sa_i = 48'h0000_0000_0001;
   logic [1:0] lookup_src_port_i = 2'h1;
   logic lookup_done_o;
   logic lookup_hit_o;
   logic lookup_drop_o;
   logic [2:0] lookup_egress_o;
   logic [1:0] lookup_prio_o;
   logic lookup_prio_valid_o;
   logic [7:0] res;
   int mismatches = 0;
   int check_count = 0;

   always #10 clock_i = ~clock_i;

   // Aging period of twenty cycles instead of minutes
   lkp_entry_write #(.DEPTH(32), .AGE_TICK_CYCLES(40'h14)) dut_u (
      .clock_i(clock_i), .rst_i(rst_i), .reg_addr_i(reg_addr_i),
      .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i),
      .reg_rdata_o(reg_rdata_o), .port_forwarding_i(port_forwarding_i),
      .lookup_req_i(lookup_req_i), .lookup_da_i(lookup_da_i),
      .lookup_sa_i(lookup_sa_i), .lookup_src_port_i(lookup_src_port_i),
      .lookup_done_o(lookup_done_o), .lookup_hit_o(lookup_hit_o),
      .lookup_drop_o(lookup_drop_o), .lookup_egress_o(lookup_egress_o),
      .lookup_prio_o(lookup_prio_o),
      .lookup_prio_valid_o(lookup_prio_valid_o)
   );

   task automatic end_of_test();
      $display("mismatches %0d of %0d checks", mismatches, check_count);
      if (mismatches == 0 && check_count > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      check_count++;
      if (got !== exp) begin
         mismatches++;
         $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   function automatic logic [31:0] hw(input logic [8:0] f,
      input logic [15:0] t);
      return {7'h00, f, t};
   endfunction

   task automatic wr(input logic [15:0] a, input logic [31:0] d);
      @(posedge clock_i);
      reg_wr_i <= 1'b1;
      reg_addr_i <= a;
      reg_wdata_i <= d;
      @(posedge clock_i);
      reg_wr_i <= 1'b0;
   endtask

   task automatic rd(input logic [15:0] a, output logic [31:0] d);
      @(posedge clock_i);
      reg_rd_i <= 1'b1;
      reg_addr_i <= a;
      @(posedge clock_i);
      reg_rd_i <= 1'b0;
      #1 d = reg_rdata_o;
   endtask

   task automatic rdchk(input logic [15:0] a, input logic [31:0] e);
      logic [31:0] d;
      rd(a, d);
      chk(d, e);
   endtask

   task automatic lk(input logic [15:0] tail);
      @(posedge clock_i);
      lookup_req_i <= 1'b1;
      lookup_da_i <= {tail, LOW};
      @(posedge clock_i);
      lookup_req_i <= 1'b0;
      #1 res = {lookup_hit_o, lookup_drop_o, lookup_egress_o, lookup_prio_o,
         lookup_prio_valid_o};
   endtask

   // Stage both words, start the command, poll for completion, then clear
   task automatic mk(input logic [31:0] high);
      logic [31:0] s;
      wr(lkp_pkg::REG_WR_LOW, LOW);
      wr(lkp_pkg::REG_WR_HIGH, high);
      @(posedge clock_i);
      reg_wr_i <= 1'b1;
      reg_addr_i <= lkp_pkg::REG_CMD;
      reg_wdata_i <= 32'h0000_0004;
      @(posedge clock_i);
      reg_wr_i <= 1'b0;
      reg_rd_i <= 1'b1;
      reg_addr_i <= lkp_pkg::REG_STATUS;
      @(posedge clock_i);
      reg_rd_i <= 1'b0;
      #1 chk(reg_rdata_o, 32'h0000_0001);
      s = 32'h0000_0001;
      for (int n = 0; n < 8 && s !== 32'h0; n++)
         rd(lkp_pkg::REG_STATUS, s);
      if (s !== 32'h0) begin
         mismatches++;
         end_of_test();
      end
      wr(lkp_pkg::REG_CMD, 32'h0000_0000);
   endtask

   task automatic t_reset_regs();
      rdchk(lkp_pkg::REG_CMD, 32'h0000_0000);
      rdchk(lkp_pkg::REG_WR_LOW, 32'h0000_0000);
      rdchk(lkp_pkg::REG_WR_HIGH, 32'h0000_0000);
      rdchk(lkp_pkg::REG_STATUS, 32'h0000_0000);
      rdchk(16'h1803, 32'h0000_0000);
   endtask

   task automatic t_high_word();
      wr(lkp_pkg::REG_WR_HIGH, 32'hFFFF_FFFF);
      rdchk(lkp_pkg::REG_WR_HIGH, 32'h01FF_FFFF);
      wr(lkp_pkg::REG_CMD, 32'hFFFF_FFFF);
      rdchk(lkp_pkg::REG_CMD, 32'h0000_0004);
      wr(lkp_pkg::REG_CMD, 32'h0000_0000);
   endtask

   // Static entries with override: every code but reserved 3 forwards with ports blocked; code 3 drops
   task automatic t_port_codes();
      logic [2:0] egr [8] = '{3'h1, 3'h2, 3'h4, 3'h0, 3'h3, 3'h5, 3'h6, 3'h7};
      port_forwarding_i <= 3'h0;
      for (int c = 0; c < 8; c++) begin
         mk(hw(9'h1C0 | 9'(c), 16'hA000 | 16'(c)));
         lk(16'hA000 | 16'(c));
         if (c == 3)
            chk(32'(res[7:6]), 32'h3);
         else
            chk(32'(res), {24'h0, 2'b10, egr[c], 3'h0});
      end
   endtask

   task automatic t_port_state();
      mk(hw(9'h147, 16'hB007));
      port_forwarding_i <= 3'h3;
      lk(16'hB007);
      chk(32'(res[7:3]), 32'h13);
      @(posedge clock_i);
      port_forwarding_i <= 3'h5;
      lk(16'hB007);
      chk(32'(res[6]), 32'h1);
      @(posedge clock_i);
      port_forwarding_i <= 3'h7;
      mk(hw(9'h161, 16'hB100));
      lk(16'hB100);
      chk(32'(res[7:6]), 32'h3);
   endtask

   task automatic t_prio_age();
      wr(lkp_pkg::REG_INGRESS, 32'h0000_0020);
      rdchk(lkp_pkg::REG_INGRESS, 32'h0000_0020);
      mk(hw(9'h152, 16'hC000));
      lk(16'hC000);
      chk(32'(res), 32'hA5);
      mk(hw(9'h19A, 16'hC001));
      lk(16'hC001);
      chk(32'({res[7], res[0]}), 32'h2);
      // Idle for three aging periods: the dynamic entry must be gone
      repeat (60) @(posedge clock_i);
      lk(16'hC001);
      chk(32'(res), 32'h0);
      lk(16'hC000);
      chk(32'(res), 32'hA5);
      // A static entry keeps its port when its MAC arrives as a source
      @(posedge clock_i);
      lookup_sa_i <= {16'hC000, LOW};
      lk(16'hC000);
      @(posedge clock_i);
      lookup_sa_i <= 48'h0000_0000_0001;
      lk(16'hC000);
      chk(32'(res), 32'hA5);
      wr(lkp_pkg::REG_INGRESS, 32'h0000_0000);
   endtask

   task automatic t_invalidate();
      mk(hw(9'h141, 16'hD001));
      lk(16'hD001);
      chk(32'(res[7]), 32'h1);
      mk(hw(9'h001, 16'hD001));
      rdchk(lkp_pkg::REG_WR_HIGH, 32'h0001_D001);
      lk(16'hD001);
      chk(32'(res), 32'h0);
   endtask

   // Cut a hang short
   initial begin
      repeat (5000) @(posedge clock_i);
      mismatches++;
      end_of_test();
   end

   initial begin
      repeat (20) @(posedge clock_i);
      rst_i <= 1'b0;
      t_reset_regs();
      t_high_word();
      t_port_codes();
      t_port_state();
      t_prio_age();
      t_invalidate();
      end_of_test();
   end
endmodule // lkp_entry_write_tb_top
